// ---- sgp_pkg.sv ----
// shared constants and carrier types for the shared gpio ports c, d and e
package sgp_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] SGP_IDX_PORT_C_DATA = 10'h002;
   localparam logic [9:0] SGP_IDX_PORT_D_DATA = 10'h003;
   localparam logic [9:0] SGP_IDX_PORT_E_DATA = 10'h008;
   localparam logic [9:0] SGP_IDX_PORT_C_DIRECTION = 10'h00C;
   localparam logic [9:0] SGP_IDX_PORT_D_DIRECTION = 10'h00D;
   localparam logic [9:0] SGP_IDX_PORT_E_DIRECTION = 10'h00E;
   localparam int SGP_ADDR_W = 12;
   localparam int SGP_DATA_W = 32;
   // port widths
   localparam int SGP_C_W = 5;
   localparam int SGP_D_W = 2;
   localparam int SGP_E_W = 2;
   localparam int SGP_PINS = SGP_C_W + SGP_D_W + SGP_E_W;
   // field positions
   localparam int SGP_C_CLK_PIN = 2;
   localparam int SGP_C_CLKEN_BIT = 7;
   localparam int SGP_E_RX_PIN = 1;
   localparam int SGP_E_TX_PIN = 0;
   localparam int SGP_D_BASE = SGP_C_W;
   localparam int SGP_E_BASE = SGP_C_W + SGP_D_W;
   // reset values
   localparam logic [4:0] SGP_C_DIR_RST = 5'h00;
   localparam logic [1:0] SGP_D_DIR_RST = 2'h0;
   localparam logic [1:0] SGP_E_DIR_RST = 2'h0;
   localparam logic SGP_CLKEN_RST = 1'b0;
   localparam logic [31:0] SGP_RD_ZERO = 32'h0000_0000;
   // timing: one wait state, pready comes at the second access edge
   localparam int SGP_APB_WAIT = 1;

   typedef struct packed {
      logic [4:0] out;
      logic [4:0] oe;
   } sgp_port_c_drive_t;

   typedef struct packed {
      logic [1:0] out;
      logic [1:0] oe;
   } sgp_port2_drive_t;

   typedef struct packed {
      logic [1:0] els_high;
      logic [1:0] els_low;
      logic [1:0] out;
      logic [1:0] oe;
   } sgp_timer_t;
endpackage

// ---- sgp_pin_cell.sv ----
// one port pin: output buffer control, drive value and read-back select
`timescale 1ns/100ps
module sgp_pin_cell
   import sgp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic latch,
   input wire logic dir,
   input wire logic claim,
   input wire logic periph_out,
   input wire logic periph_oe,
   input wire logic pin_in,
   output logic out_q,
   output logic oe_q,
   output logic rd_bit
);
   logic out_d;
   logic oe_d;

   // a claiming peripheral owns the buffer; otherwise direction and latch do
   always_comb begin
      if (claim) begin
         out_d = periph_out;
         oe_d = periph_oe;
      end else begin
         out_d = latch;
         oe_d = dir;
      end
   end

   // buffer off at reset so a pin never drives before software asks
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         out_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (ce) begin
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   // direction picks latch or pin even while a peripheral drives
   assign rd_bit = dir ? latch : pin_in;
endmodule

// ---- sgp_apb_port.sv ----
// apb handshake for the port registers: one wait state, error on a miss
`timescale 1ns/100ps
module sgp_apb_port
   import sgp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic hit,
   output logic pready_q,
   output logic pslverr_q,
   output logic load,
   output logic wr_stb
);
   // load marks the first access cycle: read data and answer are captured
   assign load = psel & penable & ~pready_q;
   // the write lands only on the edge where the master sees pready
   assign wr_stb = psel & penable & pready_q & pwrite;

   // pready lasts one cycle so the next transfer is never answered early
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q <= load;
         pslverr_q <= load & ~hit;
      end
   end
endmodule

// ---- sgp_ports.sv ----
// top: apb registers and pin logic for shared gpio ports c, d and e
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module sgp_ports
   import sgp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0] port_c_pin_in,
   output sgp_port_c_drive_t port_c_drive,
   input wire logic [1:0] port_d_pin_in,
   output sgp_port2_drive_t port_d_drive,
   input wire logic [1:0] port_e_pin_in,
   output sgp_port2_drive_t port_e_drive,
   input wire sgp_timer_t timer_a_module,
   output logic [1:0] timer_a_channel_in,
   input wire logic serial_if_enable,
   input wire logic port_e_pin_zero_transmit,
   output logic port_e_pin_one_receive
);
   // software state
   logic [4:0] port_c_latch_q;
   logic [1:0] port_d_latch_q;
   logic [1:0] port_e_latch_q;
   logic [4:0] port_c_direction_q;
   logic [1:0] port_d_direction_q;
   logic [1:0] port_e_direction_q;
   logic sysclk_out_enable_q;
   logic sysclk_div_q;
   logic [31:0] prdata_q;
   logic [1:0] timer_in_q;
   logic rx_in_q;
   // bus decode
   logic [9:0] idx;
   logic aligned;
   logic hit;
   logic load;
   logic wr_stb;
   logic sel_c_data;
   logic sel_d_data;
   logic sel_e_data;
   logic sel_c_dir;
   logic sel_d_dir;
   logic sel_e_dir;
   logic [31:0] rd_d;
   // flattened pin vectors, port c at bit 0, then d, then e
   logic [SGP_PINS-1:0] all_latch;
   logic [SGP_PINS-1:0] all_dir;
   logic [SGP_PINS-1:0] all_claim;
   logic [SGP_PINS-1:0] all_pout;
   logic [SGP_PINS-1:0] all_poe;
   logic [SGP_PINS-1:0] all_pin;
   logic [SGP_PINS-1:0] all_out_q;
   logic [SGP_PINS-1:0] all_oe_q;
   logic [SGP_PINS-1:0] all_rd;
   logic [1:0] timer_claim;

   // word-aligned index decode; unaligned or unmapped answers with pslverr
   assign idx = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign sel_c_data = aligned && (idx == SGP_IDX_PORT_C_DATA);
   assign sel_d_data = aligned && (idx == SGP_IDX_PORT_D_DATA);
   assign sel_e_data = aligned && (idx == SGP_IDX_PORT_E_DATA);
   assign sel_c_dir = aligned && (idx == SGP_IDX_PORT_C_DIRECTION);
   assign sel_d_dir = aligned && (idx == SGP_IDX_PORT_D_DIRECTION);
   assign sel_e_dir = aligned && (idx == SGP_IDX_PORT_E_DIRECTION);
   assign hit = sel_c_data | sel_d_data | sel_e_data | sel_c_dir | sel_d_dir | sel_e_dir;

   sgp_apb_port u_apb (
      .clk_sys(clk_sys),
      .reset(reset),
      .ce(ce),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .hit(hit),
      .pready_q(pready),
      .pslverr_q(pslverr),
      .load(load),
      .wr_stb(wr_stb)
   );

   // direction registers and clock-out enable; cleared by reset
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         port_c_direction_q <= SGP_C_DIR_RST;
         sysclk_out_enable_q <= SGP_CLKEN_RST;
         port_d_direction_q <= SGP_D_DIR_RST;
         port_e_direction_q <= SGP_E_DIR_RST;
      end else if (ce && wr_stb) begin
         if (sel_c_dir) begin
            port_c_direction_q <= pwdata[4:0];
            sysclk_out_enable_q <= pwdata[SGP_C_CLKEN_BIT];
         end
         if (sel_d_dir) begin
            port_d_direction_q <= pwdata[1:0];
         end
         if (sel_e_dir) begin
            port_e_direction_q <= pwdata[1:0];
         end
      end
   end

   // data latches have no reset: their content survives a reset
   always_ff @(posedge clk_sys) begin
      if (ce && wr_stb) begin
         if (sel_c_data) begin
            port_c_latch_q[1:0] <= pwdata[1:0];
            port_c_latch_q[4:3] <= pwdata[4:3];
            if (!sysclk_out_enable_q) begin
               port_c_latch_q[SGP_C_CLK_PIN] <= pwdata[SGP_C_CLK_PIN];
            end
         end
         if (sel_d_data) begin
            port_d_latch_q <= pwdata[1:0];
         end
         if (sel_e_data) begin
            port_e_latch_q <= pwdata[1:0];
         end
      end
   end

   // clock out is the system clock halved, since a pin flop cannot toggle faster
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sysclk_div_q <= 1'b0;
      end else if (ce) begin
         sysclk_div_q <= sysclk_out_enable_q ? ~sysclk_div_q : 1'b0;
      end
   end

   // a channel is the timer's when either edge/level select bit is set
   assign timer_claim = timer_a_module.els_high | timer_a_module.els_low;

   // peripheral claims and drive sources
   always_comb begin
      all_claim = '0;
      all_pout = '0;
      all_poe = '0;
      all_claim[SGP_C_CLK_PIN] = sysclk_out_enable_q;
      all_pout[SGP_C_CLK_PIN] = sysclk_div_q;
      all_poe[SGP_C_CLK_PIN] = 1'b1;
      all_claim[SGP_D_BASE +: SGP_D_W] = timer_claim;
      all_pout[SGP_D_BASE +: SGP_D_W] = timer_a_module.out;
      all_poe[SGP_D_BASE +: SGP_D_W] = timer_a_module.oe;
      all_claim[SGP_E_BASE + SGP_E_RX_PIN] = serial_if_enable;
      all_poe[SGP_E_BASE + SGP_E_RX_PIN] = 1'b0;
      all_claim[SGP_E_BASE + SGP_E_TX_PIN] = serial_if_enable;
      all_pout[SGP_E_BASE + SGP_E_TX_PIN] = port_e_pin_zero_transmit;
      all_poe[SGP_E_BASE + SGP_E_TX_PIN] = 1'b1;
   end

   assign all_latch = {port_e_latch_q, port_d_latch_q, port_c_latch_q};
   assign all_dir = {port_e_direction_q, port_d_direction_q, port_c_direction_q};
   assign all_pin = {port_e_pin_in, port_d_pin_in, port_c_pin_in};

   // one cell per pin
   generate
      for (genvar i = 0; i < SGP_PINS; i++) begin : g_pin
         sgp_pin_cell u_cell (
            .clk_sys(clk_sys),
            .reset(reset),
            .ce(ce),
            .latch(all_latch[i]),
            .dir(all_dir[i]),
            .claim(all_claim[i]),
            .periph_out(all_pout[i]),
            .periph_oe(all_poe[i]),
            .pin_in(all_pin[i]),
            .out_q(all_out_q[i]),
            .oe_q(all_oe_q[i]),
            .rd_bit(all_rd[i])
         );
      end
   endgenerate

   assign port_c_drive.out = all_out_q[SGP_C_W-1:0];
   assign port_c_drive.oe = all_oe_q[SGP_C_W-1:0];
   assign port_d_drive.out = all_out_q[SGP_D_BASE +: SGP_D_W];
   assign port_d_drive.oe = all_oe_q[SGP_D_BASE +: SGP_D_W];
   assign port_e_drive.out = all_out_q[SGP_E_BASE +: SGP_E_W];
   assign port_e_drive.oe = all_oe_q[SGP_E_BASE +: SGP_E_W];

   // pin levels handed to the timer and serial blocks, one flop each
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         timer_in_q <= 2'h0;
         rx_in_q <= 1'b1;
      end else if (ce) begin
         timer_in_q <= port_d_pin_in;
         rx_in_q <= port_e_pin_in[SGP_E_RX_PIN];
      end
   end
   assign timer_a_channel_in = timer_in_q;
   assign port_e_pin_one_receive = rx_in_q;

   // read mux; reserved bits read zero
   always_comb begin
      rd_d = SGP_RD_ZERO;
      if (sel_c_data) begin
         rd_d[4:0] = all_rd[SGP_C_W-1:0];
         if (sysclk_out_enable_q) begin
            rd_d[SGP_C_CLK_PIN] = 1'b0;
         end
      end
      if (sel_d_data) begin
         rd_d[1:0] = all_rd[SGP_D_BASE +: SGP_D_W];
      end
      if (sel_e_data) begin
         rd_d[1:0] = all_rd[SGP_E_BASE +: SGP_E_W];
      end
      if (sel_c_dir) begin
         rd_d[4:0] = port_c_direction_q;
         rd_d[SGP_C_CLKEN_BIT] = sysclk_out_enable_q;
      end
      if (sel_d_dir) begin
         rd_d[1:0] = port_d_direction_q;
      end
      if (sel_e_dir) begin
         rd_d[1:0] = port_e_direction_q;
      end
   end

   // read data captured in the first access cycle and held until the next read
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prdata_q <= SGP_RD_ZERO;
      end else if (ce && load && !pwrite) begin
         prdata_q <= rd_d;
      end
   end
   assign prdata = prdata_q;

   // checks

   a_dir_drives_oe: assert property (@(posedge clk_sys) disable iff (reset)
      $past(ce) && !$past(sysclk_out_enable_q) |-> port_c_drive.oe == $past(port_c_direction_q))
      else $error("port c output enable does not follow direction");

   a_clk_out_runs: assert property (@(posedge clk_sys) disable iff (reset)
      $past(ce) && $past(sysclk_out_enable_q) && ce && sysclk_out_enable_q |=>
      port_c_drive.oe[SGP_C_CLK_PIN] && (port_c_drive.out[SGP_C_CLK_PIN] != $past(port_c_drive.out[SGP_C_CLK_PIN])))
      else $error("clock output not toggling while enabled");

   a_clk_pin_reads: assert property (@(posedge clk_sys) disable iff (reset)
      ce && load && !pwrite && sel_c_data && sysclk_out_enable_q |=> pready && !prdata[SGP_C_CLK_PIN])
      else $error("clock pin data bit not read as zero");

   a_clk_pin_locked: assert property (@(posedge clk_sys) disable iff (reset)
      sysclk_out_enable_q |=> port_c_latch_q[SGP_C_CLK_PIN] == $past(port_c_latch_q[SGP_C_CLK_PIN]))
      else $error("clock pin latch changed while clock output on");

   a_reset_dirs: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(reset) |-> port_c_direction_q == SGP_C_DIR_RST && !sysclk_out_enable_q &&
      port_d_direction_q == SGP_D_DIR_RST && port_e_direction_q == SGP_E_DIR_RST)
      else $error("directions not cleared by reset");

   a_read_c_src: assert property (@(posedge clk_sys) disable iff (reset)
      ce && load && !pwrite && sel_c_data |=>
      prdata[0] == ($past(port_c_direction_q[0]) ? $past(port_c_latch_q[0]) : $past(port_c_pin_in[0])))
      else $error("port c read source wrong");

   a_latch_write: assert property (@(posedge clk_sys) disable iff (reset)
      ce && wr_stb && sel_e_data |=> port_e_latch_q == $past(pwdata[1:0]) ##1 pready == 1'b0)
      else $error("port e latch write lost");

   a_timer_drive: assert property (@(posedge clk_sys) disable iff (reset)
      ce && timer_claim[0] |=> port_d_drive.oe[0] == $past(timer_a_module.oe[0]) &&
      port_d_drive.out[0] == $past(timer_a_module.out[0]))
      else $error("timer does not own claimed port d pin");

   a_read_d_src: assert property (@(posedge clk_sys) disable iff (reset)
      ce && load && !pwrite && sel_d_data |=>
      prdata[1] == ($past(port_d_direction_q[1]) ? $past(port_d_latch_q[1]) : $past(port_d_pin_in[1])))
      else $error("port d read source wrong");

   a_serial_pins: assert property (@(posedge clk_sys) disable iff (reset)
      ce && serial_if_enable |=> !port_e_drive.oe[SGP_E_RX_PIN] && port_e_drive.oe[SGP_E_TX_PIN])
      else $error("serial pins not set as receive and transmit");

   a_read_e_src: assert property (@(posedge clk_sys) disable iff (reset)
      ce && load && !pwrite && sel_e_data |=>
      prdata[0] == ($past(port_e_direction_q[0]) ? $past(port_e_latch_q[0]) : $past(port_e_pin_in[0])))
      else $error("port e read source wrong");

   a_latch_keeps: assert property (@(posedge clk_sys)
      reset && $past(reset) |->
      {port_e_latch_q, port_c_latch_q} === $past({port_e_latch_q, port_c_latch_q}))
      else $error("data latch changed during reset");

   a_plain_output: assert property (@(posedge clk_sys) disable iff (reset)
      ce && !timer_claim[1] && port_d_direction_q[1] |=> port_d_drive.oe[1] && port_d_drive.out[1] == $past(port_d_latch_q[1]))
      else $error("unclaimed output pin not driving latch");

   a_apb_wait: assert property (@(posedge clk_sys) disable iff (reset)
      ce && psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not after one wait state");
endmodule

// ---- sgp_pin_model.sv ----
// external circuitry on the three ports: driven pins follow the device, released pins the outside level
`timescale 1ns/100ps
module sgp_pin_model
   import sgp_pkg::*;
(
   input wire sgp_port_c_drive_t port_c_drive,
   input wire sgp_port2_drive_t port_d_drive,
   input wire sgp_port2_drive_t port_e_drive,
   input wire logic [4:0] ext_c,
   input wire logic [1:0] ext_d,
   input wire logic [1:0] ext_e,
   output logic [4:0] port_c_pin_in,
   output logic [1:0] port_d_pin_in,
   output logic [1:0] port_e_pin_in
);
   // a released pin never keeps the last driven value, so a missing read select shows up
   assign port_c_pin_in = (port_c_drive.oe & port_c_drive.out) | (~port_c_drive.oe & ext_c);
   assign port_d_pin_in = (port_d_drive.oe & port_d_drive.out) | (~port_d_drive.oe & ext_d);
   assign port_e_pin_in = (port_e_drive.oe & port_e_drive.out) | (~port_e_drive.oe & ext_e);
endmodule

// ---- sgp_ports_tb.sv ----
// self-checking bench for the shared gpio ports c, d and e
`timescale 1ns/100ps
module sgp_ports_tb
   import sgp_pkg::*;
;
   logic clk_sys, reset, ce, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   sgp_port_c_drive_t cdrv;
   sgp_port2_drive_t ddrv, edrv;
   logic [4:0] cpin, ext_c;
   logic [1:0] dpin, epin, ext_d, ext_e, tch;
   sgp_timer_t timer_a;
   logic ser_en, txd, rxd, e, a;
   int failures = 0;
   int tests_run = 0;

   sgp_ports u_sgp_ports (.clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_c_pin_in(cpin), .port_c_drive(cdrv), .port_d_pin_in(dpin), .port_d_drive(ddrv),
      .port_e_pin_in(epin), .port_e_drive(edrv), .timer_a_module(timer_a), .timer_a_channel_in(tch),
      .serial_if_enable(ser_en), .port_e_pin_zero_transmit(txd), .port_e_pin_one_receive(rxd));
   sgp_pin_model u_sgp_pin_model (.port_c_drive(cdrv), .port_d_drive(ddrv), .port_e_drive(edrv),
      .ext_c(ext_c), .ext_d(ext_d), .ext_e(ext_e), .port_c_pin_in(cpin), .port_d_pin_in(dpin),
      .port_e_pin_in(epin));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // one apb transfer; request held until pready is seen high, wait bounded
   task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         $display("no bus answer at %0t", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      logic [31:0] x;
      logic y;
      xfer(1'b1, {idx, 2'b00}, d, x, y);
   endtask

   task automatic rd(input logic [9:0] idx, output logic [31:0] d);
      logic y;
      xfer(1'b0, {idx, 2'b00}, 32'h0000_0000, d, y);
   endtask

   task automatic t_reset();
      rd(SGP_IDX_PORT_C_DIRECTION, r);
      chk(r, 32'h0000_0000);
      rd(SGP_IDX_PORT_D_DIRECTION, r);
      chk(r, 32'h0000_0000);
      rd(SGP_IDX_PORT_E_DIRECTION, r);
      chk(r, 32'h0000_0000);
      chk({cdrv.oe, ddrv.oe, edrv.oe}, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_port_c();
      ext_c <= 5'h0A;
      wr(SGP_IDX_PORT_C_DATA, 32'h0000_0015);
      wr(SGP_IDX_PORT_C_DIRECTION, 32'h0000_001F);
      settle(2);
      chk({cdrv.out, cdrv.oe}, {5'h15, 5'h1F});
      rd(SGP_IDX_PORT_C_DATA, r);
      chk(r, 32'h0000_0015);
      wr(SGP_IDX_PORT_C_DIRECTION, 32'h0000_0003);
      settle(2);
      chk(cdrv.oe, 5'h03);
      rd(SGP_IDX_PORT_C_DATA, r);
      chk(r, 32'h0000_0009);
      // latch written while bits 4..2 are inputs: the read still shows the pins
      wr(SGP_IDX_PORT_C_DATA, 32'h0000_0000);
      rd(SGP_IDX_PORT_C_DATA, r);
      chk(r, 32'h0000_0008);
      wr(SGP_IDX_PORT_C_DIRECTION, 32'h0000_001F);
      settle(2);
      chk(cdrv.out, 5'h00);
      $display("test port c done");
   endtask

   task automatic t_clkout();
      wr(SGP_IDX_PORT_C_DATA, 32'h0000_0004);
      wr(SGP_IDX_PORT_C_DIRECTION, 32'h0000_0080);
      settle(2);
      chk(cdrv.oe, 5'h04);
      a = cdrv.out[2];
      settle(1);
      chk(cdrv.out[2], {31'h0000_0000, ~a});
      rd(SGP_IDX_PORT_C_DATA, r);
      chk(r, 32'h0000_000A);
      wr(SGP_IDX_PORT_C_DATA, 32'h0000_0000);
      wr(SGP_IDX_PORT_C_DIRECTION, 32'h0000_0004);
      rd(SGP_IDX_PORT_C_DATA, r);
      chk(r, 32'h0000_000E);
      wr(SGP_IDX_PORT_C_DIRECTION, 32'h0000_0000);
      settle(2);
      chk(cdrv.oe, 5'h00);
      $display("test clock out done");
   endtask

   task automatic t_port_d();
      ext_d <= 2'b01;
      timer_a <= '{2'b00, 2'b01, 2'b00, 2'b00};
      wr(SGP_IDX_PORT_D_DATA, 32'h0000_0002);
      wr(SGP_IDX_PORT_D_DIRECTION, 32'h0000_0003);
      settle(3);
      chk({ddrv.oe, ddrv.out[1]}, {2'b10, 1'b1});
      chk(tch[0], 1'b1);
      rd(SGP_IDX_PORT_D_DATA, r);
      chk(r, 32'h0000_0002);
      timer_a <= '{2'b00, 2'b01, 2'b01, 2'b01};
      wr(SGP_IDX_PORT_D_DIRECTION, 32'h0000_0000);
      settle(3);
      chk({ddrv.oe, ddrv.out[0]}, {2'b01, 1'b1});
      rd(SGP_IDX_PORT_D_DATA, r);
      chk(r, 32'h0000_0001);
      timer_a <= '{2'b00, 2'b00, 2'b01, 2'b01};
      wr(SGP_IDX_PORT_D_DIRECTION, 32'h0000_0003);
      settle(3);
      chk({ddrv.out, ddrv.oe}, {2'b10, 2'b11});
      $display("test port d done");
   endtask

   task automatic t_port_e();
      ext_e <= 2'b10;
      txd <= 1'b1;
      ser_en <= 1'b1;
      wr(SGP_IDX_PORT_E_DATA, 32'h0000_0001);
      wr(SGP_IDX_PORT_E_DIRECTION, 32'h0000_0003);
      settle(3);
      chk({edrv.oe, edrv.out[0], rxd}, {2'b01, 1'b1, 1'b1});
      txd <= 1'b0;
      settle(3);
      chk(edrv.out[0], 1'b0);
      rd(SGP_IDX_PORT_E_DATA, r);
      chk(r, 32'h0000_0001);
      wr(SGP_IDX_PORT_E_DIRECTION, 32'h0000_0000);
      rd(SGP_IDX_PORT_E_DATA, r);
      chk(r, 32'h0000_0002);
      ser_en <= 1'b0;
      settle(3);
      chk(edrv.oe, 2'b00);
      wr(SGP_IDX_PORT_E_DIRECTION, 32'h0000_0003);
      settle(2);
      chk({edrv.out, edrv.oe}, {2'b01, 2'b11});
      $display("test port e done");
   endtask

   // latches survive a reset in mid-run while directions are cleared
   task automatic t_keep();
      wr(SGP_IDX_PORT_C_DATA, 32'h0000_0013);
      wr(SGP_IDX_PORT_E_DATA, 32'h0000_0002);
      reset <= 1'b1;
      settle(2);
      chk({cdrv.oe, ddrv.oe, edrv.oe}, 32'h0000_0000);
      reset <= 1'b0;
      rd(SGP_IDX_PORT_C_DIRECTION, r);
      chk(r, 32'h0000_0000);
      wr(SGP_IDX_PORT_C_DIRECTION, 32'h0000_001F);
      wr(SGP_IDX_PORT_E_DIRECTION, 32'h0000_0003);
      rd(SGP_IDX_PORT_C_DATA, r);
      chk(r, 32'h0000_0013);
      rd(SGP_IDX_PORT_E_DATA, r);
      chk(r, 32'h0000_0002);
      $display("test reset keeps latches done");
   endtask

   // clock enable low: a serial claim must not reach the pins until it returns
   task automatic t_freeze();
      ce <= 1'b0;
      txd <= 1'b1;
      ser_en <= 1'b1;
      settle(3);
      chk({edrv.out, edrv.oe}, {2'b10, 2'b11});
      ce <= 1'b1;
      settle(2);
      chk(edrv.oe, 2'b01);
      ser_en <= 1'b0;
      settle(1);
      $display("test clock enable freeze done");
   endtask

   task automatic t_miss();
      xfer(1'b0, 12'h0FC, 32'h0000_0000, r, e);
      chk(r, 32'h0000_0000);
      chk(e, 1'b1);
      xfer(1'b1, 12'h009, 32'h0000_00FF, r, e);
      chk(e, 1'b1);
      $display("test unmapped done");
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      give_verdict();
   end

   initial begin
      reset = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      ext_c = 5'h00;
      ext_d = 2'b00;
      ext_e = 2'b00;
      timer_a = '0;
      ser_en = 1'b0;
      txd = 1'b1;
      settle(8);
      reset <= 1'b0;
      t_reset();
      t_port_c();
      t_clkout();
      t_port_d();
      t_port_e();
      t_keep();
      t_freeze();
      t_miss();
      give_verdict();
   end
endmodule
